// [rtl/ssc_pkg.sv]
// Purpose: shared constants and carriers for the startup strap configuration loader
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: the strap port is sixteen bits, low byte then high byte

package ssc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] SSC_STARTUP_LATCH_OFS = 16'hF108;
  localparam logic [15:0] SSC_BUS_CFG0_OFS = 16'hF10C;
  localparam logic [15:0] SSC_BUS_CFG_OTHER_OFS = 16'hF110;
  localparam logic [15:0] SSC_STATUS_OFS = 16'hF114;
  localparam logic [15:0] SSC_RESET_CTRL_OFS = 16'hF118;

  // ****************************************
  // strap and field positions
  // ****************************************
  localparam int SSC_EMU_BIT = 0;
  localparam int SSC_PODCLIP_BIT = 1;
  localparam int SSC_BOOT_BIT = 4;
  localparam int SSC_MUX_BIT = 6;
  localparam int SSC_WIDTH_BIT = 7;
  localparam int SSC_CS_LSB = 1;
  localparam int SSC_SEG_LSB = 3;
  localparam logic [7:0] SSC_LATCH_MASK = 8'h1E;

  // ****************************************
  // encodings
  // ****************************************
  localparam logic [1:0] SSC_BUS_TYPE_FIELD_INTERNAL = 2'h0;
  localparam logic [1:0] SSC_BUS_TYPE_FIELD_DEMUX8 = 2'h0;
  localparam logic [1:0] SSC_BUS_TYPE_FIELD_MUX8 = 2'h1;
  localparam logic [1:0] SSC_BUS_TYPE_FIELD_DEMUX16 = 2'h2;
  localparam logic [1:0] SSC_BUS_TYPE_FIELD_MUX16 = 2'h3;
  localparam logic [1:0] SSC_CS_FIVE = 2'h3;
  localparam logic [1:0] SSC_CS_NONE = 2'h2;
  localparam logic [1:0] SSC_CS_TWO = 2'h1;
  localparam logic [1:0] SSC_CS_THREE = 2'h0;
  localparam logic [1:0] SSC_SEG_TWO = 2'h3;
  localparam logic [1:0] SSC_SEG_EIGHT = 2'h2;
  localparam logic [1:0] SSC_SEG_NONE = 2'h1;
  localparam logic [1:0] SSC_SEG_FOUR = 2'h0;
  localparam logic [15:0] SSC_STRAP_DEFAULT = 16'hFFFF;
  localparam logic [1:0] SSC_BUS_TYPE_FIELD_RESET = 2'h0;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } ssc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ssc_apb_rsp_s;

  typedef struct packed {
    logic hw;
    logic sw;
    logic wdt;
  } ssc_reset_src_s;

  // decoded chip-select enables from the count field
  function automatic logic [4:0] ssc_cs_mask(input logic [1:0] sel);
    logic [4:0] m;
    m = 5'h00;
    unique case (sel)
      SSC_CS_FIVE: m = 5'h1F;
      SSC_CS_NONE: m = 5'h00;
      SSC_CS_TWO: m = 5'h03;
      SSC_CS_THREE: m = 5'h07;
    endcase
    return m;
  endfunction : ssc_cs_mask

  // decoded segment lines driven from the count field
  function automatic logic [7:0] ssc_seg_mask(input logic [1:0] sel);
    logic [7:0] m;
    m = 8'h00;
    unique case (sel)
      SSC_SEG_TWO: m = 8'h03;
      SSC_SEG_EIGHT: m = 8'hFF;
      SSC_SEG_NONE: m = 8'h00;
      SSC_SEG_FOUR: m = 8'h0F;
    endcase
    return m;
  endfunction : ssc_seg_mask

endpackage : ssc_pkg

// [rtl/ssc_strap_sampler.sv]
// Purpose: samples the strap port each cycle while a reset sequence runs
// Assumes: strap pins synchronous to clk
// Notes: holds the last value seen before the sequence ends

`timescale 1ns/1ps

module ssc_strap_sampler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic seq_active,
  input wire logic [15:0] strap_in,
  output logic [15:0] strap_last,
  output logic pullup_en,
  output logic seq_end
);
  import ssc_pkg::*;

  logic seq_active_d;

  // ****************************************
  // sampling
  // ****************************************
  // continuous sampling
  // every cycle of the sequence overwrites, so only the final sample survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_last <= SSC_STRAP_DEFAULT;
    end else if (clk_en && seq_active) begin
      strap_last <= strap_in;
    end
  end

  // edge tracking to find the end of the sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_active_d <= 1'b1;
    end else if (clk_en) begin
      seq_active_d <= seq_active;
    end
  end

  assign pullup_en = seq_active;
  assign seq_end = clk_en & seq_active_d & ~seq_active;

endmodule : ssc_strap_sampler

// [rtl/ssc_apb_slave.sv]
// Purpose: APB slave front end, one wait-free access phase
// Assumes: master follows setup then access phases
// Notes: unmapped addresses answer with pslverr

`timescale 1ns/1ps

module ssc_apb_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire ssc_pkg::ssc_apb_req_s req,
  input wire logic hit,
  input wire logic [31:0] rd_word,
  output ssc_pkg::ssc_apb_rsp_s rsp,
  output logic wr_stb
);
  import ssc_pkg::*;

  // ****************************************
  // response
  // ****************************************
  // answered combinationally in the first access cycle; no wait states needed
  always_comb begin
    rsp.pready = req.psel & req.penable;
    rsp.pslverr = req.psel & req.penable & ~hit;
    rsp.prdata = (req.psel && req.penable && !req.pwrite && hit) ? rd_word : 32'h0000_0000;
  end

  assign wr_stb = req.psel & req.penable & req.pwrite & hit;

endmodule : ssc_apb_slave

// [rtl/ssc_startup_config.sv]
// Purpose: startup strap configuration loader for bus, chip selects and segments
// Assumes: strap port and reset sources synchronous to clk
// Notes: registers over APB; pod-clip mode survives soft resets
//
// Decided for this implementation: the APB slave port.

`timescale 1ns/1ps

module ssc_startup_config (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire ssc_pkg::ssc_apb_req_s apb_req,
  output ssc_pkg::ssc_apb_rsp_s apb_rsp,
  input wire ssc_pkg::ssc_reset_src_s reset_src,
  input wire logic external_start_pin,
  input wire logic [7:0] strap_port_low,
  input wire logic [7:0] strap_port_high,
  input wire logic [23:0] bus_addr,
  input wire logic [15:0] ext_addr_offset,
  output logic strap_pullup_en,
  output logic seq_end,
  output logic [1:0] bus_type_field,
  output logic low_byte_data_en,
  output logic high_byte_data_en,
  output logic [15:0] separate_address_port,
  output logic separate_address_port_oe,
  output logic [4:0] chip_select_port,
  output logic [4:0] chip_select_port_oe,
  output logic [7:0] segment_port,
  output logic [7:0] segment_port_oe,
  output logic [23:0] internal_addr,
  output logic pod_clip_mode,
  output logic reset_output_pin,
  output logic reset_output_pin_oe,
  output logic oscillator_input_en,
  output logic boot_loader_mode,
  output logic reserved_strap_low
);
  import ssc_pkg::*;

  // ****************************************
  // reset sequence tracking
  // ****************************************
  logic seq_active;
  logic hw_in_seq;
  logic [15:0] strap_last;
  logic [7:0] startup_config_latch;
  logic [1:0] bus_cfg_other;
  logic [1:0] next_bus_type;
  logic wr_stb;
  logic hit;
  logic [31:0] rd_word;
  logic nonmux_any;
  logic [4:0] cs_mask;
  logic [7:0] seg_mask;
  logic ext_start_q;
  logic running;
  logic seq_pullup;
  logic wr_cfg0;
  logic wr_cfg_other;

  // any one of the three sources keeps the sequence running
  assign seq_active = reset_src.hw | reset_src.sw | reset_src.wdt;

  // remembers whether the running sequence included a hardware reset
  // a hardware source anywhere in the sequence counts for the mode straps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hw_in_seq <= 1'b1;
    end else if (clk_en) begin
      if (reset_src.hw) begin
        hw_in_seq <= 1'b1;
      end else if (seq_end) begin
        hw_in_seq <= 1'b0;
      end
    end
  end

  ssc_strap_sampler u_sampler (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .seq_active(seq_active),
    .strap_in({strap_port_high, strap_port_low}),
    .strap_last(strap_last),
    .pullup_en(seq_pullup),
    .seq_end(seq_end)
  );

  // pod-clip keeps the pullups
  // pod-clip holds the strap port as in reset, so the pullups stay on there
  assign strap_pullup_en = seq_pullup | pod_clip_mode;

  // running flag: outputs switch over once the sequence has ended
  // hazard: every registered pin enable lags seq_end by two cycles, one behind running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
    end else if (clk_en) begin
      if (seq_active) begin
        running <= 1'b0;
      end else if (seq_end) begin
        running <= 1'b1;
      end
    end
  end

  // ****************************************
  // latched configuration
  // ****************************************
  // any reset source
  // segment latch
  // reserved bits read zero; only fields live in the latch
  // loaded once per sequence, software has no path into it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startup_config_latch <= SSC_STRAP_DEFAULT[15:8] & SSC_LATCH_MASK;
      ext_start_q <= 1'b0;
    end else if (clk_en && seq_end) begin
      startup_config_latch <= strap_last[15:8] & SSC_LATCH_MASK;
      ext_start_q <= ~external_start_pin;
    end
  end

  // strap to bus type
  // width strap is the high bit, mux strap the low bit
  always_comb begin
    next_bus_type = {strap_last[SSC_WIDTH_BIT], strap_last[SSC_MUX_BIT]};
    if (external_start_pin) begin
      next_bus_type = SSC_BUS_TYPE_FIELD_INTERNAL;
    end
  end

  // software override
  // a seq_end load wins over a write in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_type_field <= SSC_BUS_TYPE_FIELD_RESET;
    end else if (clk_en) begin
      if (seq_end) begin
        bus_type_field <= next_bus_type;
      end else if (wr_cfg0) begin
        bus_type_field <= apb_req.pwdata[1:0];
      end
    end
  end

  // type field of the other bus configuration registers, software only
  // forced back to the multiplexed default during any sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_cfg_other <= SSC_BUS_TYPE_FIELD_MUX16;
    end else if (clk_en) begin
      if (seq_active) begin
        bus_cfg_other <= SSC_BUS_TYPE_FIELD_MUX16;
      end else if (wr_cfg_other) begin
        bus_cfg_other <= apb_req.pwdata[1:0];
      end
    end
  end

  // ****************************************
  // operating modes
  // ****************************************
  // pod-clip entry
  // pod-clip exit on hardware reset only
  // loader exit on soft reset
  // soft and watchdog sequences clear the loader but leave pod-clip alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pod_clip_mode <= 1'b0;
      boot_loader_mode <= 1'b0;
    end else if (clk_en && seq_end) begin
      if (hw_in_seq) begin
        pod_clip_mode <= ~strap_last[SSC_PODCLIP_BIT];
        boot_loader_mode <= ~strap_last[SSC_BOOT_BIT];
      end else begin
        boot_loader_mode <= 1'b0;
      end
    end
  end

  // board keeps these high
  // flag only: the hazard lies with the board, so it is reported, not fixed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reserved_strap_low <= 1'b0;
    end else if (clk_en && seq_end) begin
      reserved_strap_low <= ~&{strap_last[SSC_EMU_BIT], strap_last[3:2], strap_last[5],
                               strap_last[8], strap_last[15:13]};
    end
  end

  // ****************************************
  // pin control
  // ****************************************
  assign cs_mask = ssc_cs_mask(startup_config_latch[SSC_CS_LSB +: 2]);
  assign seg_mask = ssc_seg_mask(startup_config_latch[SSC_SEG_LSB +: 2]);
  assign nonmux_any = ~bus_type_field[0] | ~bus_cfg_other[0];

  // pod-clip pins
  // pod-clip releases the reset output and disables the oscillator input, unlike reset
  // the reset output is released rather than driven once the device runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_output_pin <= 1'b0;
      reset_output_pin_oe <= 1'b1;
      oscillator_input_en <= 1'b1;
    end else if (clk_en) begin
      reset_output_pin <= 1'b0;
      reset_output_pin_oe <= ~pod_clip_mode & ~running;
      oscillator_input_en <= ~pod_clip_mode;
    end
  end

  // demux 8-bit high byte free
  // trade-off: a register stage per pin keeps the enables glitch-free
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_byte_data_en <= 1'b0;
      high_byte_data_en <= 1'b0;
    end else if (clk_en) begin
      low_byte_data_en <= running & ~pod_clip_mode;
      high_byte_data_en <= running & ~pod_clip_mode & (bus_type_field != SSC_BUS_TYPE_FIELD_DEMUX8);
    end
  end

  // drive whenever any demux
  // the port is released, not driven low, while no demux is set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      separate_address_port <= 16'h0000;
      separate_address_port_oe <= 1'b0;
    end else if (clk_en) begin
      separate_address_port <= ext_addr_offset;
      separate_address_port_oe <= running & ~pod_clip_mode & nonmux_any;
    end
  end

  // decoded count
  // chip selects are active low, so an idle line reads one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_select_port <= 5'h1F;
      chip_select_port_oe <= 5'h00;
    end else if (clk_en) begin
      chip_select_port_oe <= (running && !pod_clip_mode) ? cs_mask : 5'h00;
      chip_select_port <= 5'h1F;
      if (running && ext_start_q && cs_mask[1]) begin
        chip_select_port <= 5'h1E;
      end
    end
  end

  // decoded count
  // unselected segment lines stay released for general I/O
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      segment_port <= 8'h00;
      segment_port_oe <= 8'h00;
    end else if (clk_en) begin
      segment_port <= bus_addr[23:16] & seg_mask;
      segment_port_oe <= (running && !pod_clip_mode) ? seg_mask : 8'h00;
    end
  end

  // full 24-bit decode
  // internal decode never sees the pin count, only the full address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      internal_addr <= 24'h00_0000;
    end else if (clk_en) begin
      internal_addr <= bus_addr;
    end
  end

  // ****************************************
  // register bus
  // ****************************************
  // writes that reach a live field; read-only offsets fall through unheard
  assign wr_cfg0 = wr_stb & (apb_req.paddr == SSC_BUS_CFG0_OFS);
  assign wr_cfg_other = wr_stb & (apb_req.paddr == SSC_BUS_CFG_OTHER_OFS);

  // read decode; unmapped offsets answer with an error
  always_comb begin
    hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (apb_req.paddr)
      SSC_STARTUP_LATCH_OFS: rd_word = {24'h00_0000, startup_config_latch};
      SSC_BUS_CFG0_OFS: rd_word = {30'h0000_0000, bus_type_field};
      SSC_BUS_CFG_OTHER_OFS: rd_word = {30'h0000_0000, bus_cfg_other};
      SSC_STATUS_OFS: rd_word = {28'h000_0000, reserved_strap_low, boot_loader_mode,
                                 pod_clip_mode, ext_start_q};
      // the last raw sample stays visible for board bring-up
      SSC_RESET_CTRL_OFS: rd_word = {16'h0000, strap_last};
      default: hit = 1'b0;
    endcase
  end

  ssc_apb_slave u_apb (
    .clk(clk),
    .rst_n(rst_n),
    .req(apb_req),
    .hit(hit),
    .rd_word(rd_word),
    .rsp(apb_rsp),
    .wr_stb(wr_stb)
  );

endmodule : ssc_startup_config

// [test/ssc_startup_config_asserts.sv]
// Purpose: port-level checks on the startup strap loader
// Assumes: clk_en held high, so every cycle of a sequence samples
// Notes: keeps its own copy of the last strap sample of a sequence
`timescale 1ns/1ps

module ssc_startup_config_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire ssc_pkg::ssc_reset_src_s reset_src,
  input wire logic external_start_pin,
  input wire logic [7:0] strap_port_low,
  input wire logic [7:0] strap_port_high,
  input wire logic [23:0] bus_addr,
  input wire logic seq_end,
  input wire logic [1:0] bus_type_field,
  input wire logic [4:0] chip_select_port,
  input wire logic [4:0] chip_select_port_oe,
  input wire logic [7:0] segment_port_oe,
  input wire logic [23:0] internal_addr,
  input wire logic pod_clip_mode,
  input wire logic reset_output_pin_oe,
  input wire logic oscillator_input_en,
  input wire logic boot_loader_mode
);
  import ssc_pkg::*;
  // ********
  // helpers
  // ********
  logic any_rst;
  logic hw_seen;
  logic [15:0] smp;
  logic [4:0] cs_exp;
  logic [7:0] seg_exp;
  assign any_rst = |reset_src;
  // last strap value seen while a sequence runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      smp <= SSC_STRAP_DEFAULT;
    end else if (any_rst) begin
      smp <= {strap_port_high, strap_port_low};
    end
  end
  // power-on reset counts as hardware, so start set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hw_seen <= 1'b1;
    end else if (reset_src.hw) begin
      hw_seen <= 1'b1;
    end else if (seq_end) begin
      hw_seen <= 1'b0;
    end
  end
  // expected pin enables, written out apart from the design's decode
  assign cs_exp = smp[10:9] == 2'h3 ? 5'h1F : smp[10:9] == 2'h2 ? 5'h00 :
                  smp[10:9] == 2'h1 ? 5'h03 : 5'h07;
  assign seg_exp = smp[12:11] == 2'h3 ? 8'h03 : smp[12:11] == 2'h2 ? 8'hFF :
                   smp[12:11] == 2'h1 ? 8'h00 : 8'h0F;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_bus_type_field_ext;
    seq_end && !external_start_pin |=> bus_type_field == smp[7:6];
  endproperty
  a_bus_type_field_ext: assert property (p_bus_type_field_ext) else $error("bus type not strapped");
  property p_bus_type_field_int;
    seq_end && external_start_pin |=> bus_type_field == 2'h0;
  endproperty
  a_bus_type_field_int: assert property (p_bus_type_field_int) else $error("bus type not zero");
  property p_cs_zero;
    seq_end && smp[10:9] != SSC_CS_NONE |-> ##2
      pod_clip_mode || chip_select_port[0] == $past(external_start_pin, 2);
  endproperty
  a_cs_zero: assert property (p_cs_zero) else $error("chip select zero level");
  property p_cs_oe;
    seq_end |-> ##2 pod_clip_mode || chip_select_port_oe == cs_exp;
  endproperty
  a_cs_oe: assert property (p_cs_oe) else $error("chip select count");
  property p_seg_oe;
    seq_end |-> ##2 pod_clip_mode || segment_port_oe == seg_exp;
  endproperty
  a_seg_oe: assert property (p_seg_oe) else $error("segment line count");
  property p_hold;
    !any_rst && !seq_end && !$past(seq_end) ##1 !any_rst |->
      $stable(chip_select_port_oe) && $stable(segment_port_oe);
  endproperty
  a_hold: assert property (p_hold) else $error("line counts moved");
  property p_pod;
    seq_end && hw_seen && !smp[SSC_PODCLIP_BIT] |-> ##2
      pod_clip_mode && !reset_output_pin_oe && !oscillator_input_en;
  endproperty
  a_pod: assert property (p_pod) else $error("pod-clip not entered");
  property p_pod_keep;
    seq_end && !hw_seen |=> pod_clip_mode == $past(pod_clip_mode);
  endproperty
  a_pod_keep: assert property (p_pod_keep) else $error("pod-clip changed");
  property p_boot;
    seq_end |=> boot_loader_mode == ($past(hw_seen) && !smp[SSC_BOOT_BIT]);
  endproperty
  a_boot: assert property (p_boot) else $error("boot loader mode");
  property p_addr;
    1'b1 |=> internal_addr == $past(bus_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("internal address");
endmodule : ssc_startup_config_asserts

bind ssc_startup_config ssc_startup_config_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .reset_src(reset_src), .external_start_pin(external_start_pin),
  .strap_port_low(strap_port_low), .strap_port_high(strap_port_high), .bus_addr(bus_addr),
  .seq_end(seq_end), .bus_type_field(bus_type_field), .chip_select_port(chip_select_port),
  .chip_select_port_oe(chip_select_port_oe), .segment_port_oe(segment_port_oe),
  .internal_addr(internal_addr), .pod_clip_mode(pod_clip_mode),
  .reset_output_pin_oe(reset_output_pin_oe), .oscillator_input_en(oscillator_input_en),
  .boot_loader_mode(boot_loader_mode)
);

// [test/ssc_board_straps.sv]
// Purpose: board strap resistors on the strap port
// Assumes: bench sets the pulldown mask per sequence
// Notes: an unpulled pin floats once the pullups release
`timescale 1ns/1ps

module ssc_board_straps (
  input wire logic clk,
  input wire logic pullup_en,
  input wire logic [15:0] pull_low,
  output logic [7:0] port_low,
  output logic [7:0] port_high
);
  // ********
  // resistors
  // ********
  logic [15:0] drop;
  logic [15:0] drift = 16'hA5A5;
  // emulation and reserved pins kept high
  assign drop = pull_low & 16'h1ED2;
  // floating pins wander so a late sample cannot pass by luck
  always @(posedge clk) drift <= ~drift;
  // pullups only in reset or pod-clip, pulldowns always win
  assign {port_high, port_low} = ~drop & (pullup_en ? 16'hFFFF : drift);
endmodule : ssc_board_straps

// [test/test_ssc_startup_config.sv]
// Purpose: scenario bench for the startup strap loader
// Assumes: clk_en tied high, registers over APB
// Notes: each scenario ends its own reset sequences
`timescale 1ns/1ps

module test_ssc_startup_config;
  import ssc_pkg::*;
  // ********
  // bench
  // ********
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ssc_apb_req_s req = '0;
  ssc_apb_rsp_s rsp;
  ssc_reset_src_s rsrc = 3'h4;
  logic ext = 1'b0;
  logic [15:0] pd = 16'h0000;
  logic [23:0] baddr = 24'h000000;
  logic [7:0] sl, sh, seg_oe;
  logic [4:0] cs_port, cs_oe;
  logic [1:0] bt;
  logic [31:0] q;
  logic e, pu, se, lo_en, hi_en, sap_oe, pod, ro_oe, osc, boot;
  logic [4:0] cs_tab [4] = '{5'h07, 5'h03, 5'h00, 5'h1F};
  logic [7:0] seg_tab [4] = '{8'h0F, 8'h00, 8'hFF, 8'h03};
  int fails = 0;
  int comparisons = 0;

  ssc_startup_config uut (
    .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .apb_req(req), .apb_rsp(rsp),
    .reset_src(rsrc), .external_start_pin(ext), .strap_port_low(sl), .strap_port_high(sh),
    .bus_addr(baddr), .ext_addr_offset(16'h0000), .strap_pullup_en(pu), .seq_end(se),
    .bus_type_field(bt), .low_byte_data_en(lo_en), .high_byte_data_en(hi_en),
    .separate_address_port(), .separate_address_port_oe(sap_oe), .chip_select_port(cs_port),
    .chip_select_port_oe(cs_oe), .segment_port(), .segment_port_oe(seg_oe), .internal_addr(),
    .pod_clip_mode(pod), .reset_output_pin(), .reset_output_pin_oe(ro_oe),
    .oscillator_input_en(osc), .boot_loader_mode(boot), .reserved_strap_low()
  );
  ssc_board_straps board (.clk(clk), .pullup_en(pu), .pull_low(pd), .port_low(sl), .port_high(sh));

  // clock and a moving access address
  always #10 clk = ~clk;
  always @(posedge clk) baddr <= baddr + 24'h010203;

  task automatic stop_test;
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : check

  // one APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1 && ++n < 20);
    check("pready", 1, rsp.pready);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : apb

  // pulldown mask from codes; a set pod or boot flag pulls that strap low
  function automatic logic [15:0] mk(input logic [1:0] b, input logic [1:0] c,
                                     input logic [1:0] s, input logic pl, input logic bl);
    return {3'h0, ~s, ~c, 1'b0, ~b, 1'b0, bl, 2'h0, pl, 1'b0};
  endfunction : mk

  // one sequence: other straps first, the final ones just before the end
  task automatic run_seq(input int kind, input logic [15:0] fin, input logic x);
    int n;
    n = 0;
    @(posedge clk);
    pd <= ~fin;
    ext <= x;
    rsrc <= 3'h4 >> kind;
    repeat (4) @(posedge clk);
    check("pullup", 1, pu);
    pd <= fin;
    repeat (3) @(posedge clk);
    rsrc <= 3'h0;
    do @(posedge clk); while (se !== 1'b1 && ++n < 10);
    check("seq end", 1, se);
    // registered pins settle one edge after the edge that samples seq_end
    @(posedge clk);
    #1;
  endtask : run_seq

  task automatic t_codes;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      run_seq(i % 3, mk(c, c, c, 1'b0, 1'b0), 1'b0);
      check("pullup off", 0, pu);
      check("bus type", c, bt);
      check("cs oe", cs_tab[c], cs_oe);
      check("seg oe", seg_tab[c], seg_oe);
      if (c != 2'h2) check("cs zero", 0, cs_port[0]);
      check("addr oe", !c[0], sap_oe);
      if (c == 2'h0) check("high byte", 0, hi_en);
      if (c == 2'h0) check("low byte", 1, lo_en);
      apb(1'b0, SSC_STARTUP_LATCH_OFS, '0);
      check("latch", {c, c}, q[4:1]);
    end
  endtask : t_codes

  task automatic t_regs;
    apb(1'b1, SSC_BUS_CFG0_OFS, 32'h1);
    apb(1'b0, SSC_BUS_CFG0_OFS, '0);
    check("cfg0 read", 1, q[1:0]);
    check("bus type", 1, bt);
    apb(1'b1, SSC_BUS_CFG_OTHER_OFS, 32'h2);
    apb(1'b0, SSC_BUS_CFG_OTHER_OFS, '0);
    check("addr oe on", 1, sap_oe);
    apb(1'b1, SSC_BUS_CFG_OTHER_OFS, 32'h3);
    apb(1'b1, SSC_STARTUP_LATCH_OFS, 32'h0);
    apb(1'b0, SSC_STARTUP_LATCH_OFS, '0);
    check("latch kept", 4'hF, q[4:1]);
    check("addr oe off", 0, sap_oe);
    apb(1'b0, 16'hF200, '0);
    check("unmapped error", 1, e);
  endtask : t_regs

  task automatic t_start;
    run_seq(1, mk(2'h2, 2'h3, 2'h3, 1'b0, 1'b0), 1'b1);
    check("internal type", 0, bt);
    check("cs zero high", 1, cs_port[0]);
  endtask : t_start

  task automatic t_modes;
    run_seq(0, mk(2'h3, 2'h3, 2'h3, 1'b1, 1'b0), 1'b0);
    check("pod", 1, pod);
    check("reset pin oe", 0, ro_oe);
    check("osc", 0, osc);
    check("pod pullup", 1, pu);
    run_seq(1, mk(2'h3, 2'h3, 2'h3, 1'b0, 1'b0), 1'b0);
    check("pod kept", 1, pod);
    run_seq(0, mk(2'h3, 2'h3, 2'h3, 1'b0, 1'b1), 1'b0);
    check("pod left", 0, pod);
    check("boot", 1, boot);
    run_seq(1, mk(2'h3, 2'h3, 2'h3, 1'b0, 1'b1), 1'b0);
    check("boot soft", 0, boot);
    run_seq(0, mk(2'h3, 2'h3, 2'h3, 1'b0, 1'b1), 1'b0);
    run_seq(0, mk(2'h3, 2'h3, 2'h3, 1'b0, 1'b0), 1'b0);
    check("boot hard", 0, boot);
  endtask : t_modes

  // main sequence after a hardware reset
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_codes();
    t_regs();
    t_start();
    t_modes();
    stop_test();
  end

  // hang guard, far beyond the couple of hundred cycles needed
  initial begin
    #200000;
    fails++;
    stop_test();
  end
endmodule : test_ssc_startup_config
